/* design/pbp_top.sv */
// parallel host bus port: pins, byte array, apb control and interrupts
// Operation
// [RQ1] shared ad lines carry the 8-bit data for every read and write
// [RQ2] multiplexed styles take the address from addr_hi and the ad lines
// [RQ3] low dedicated address lines are ignored in multiplexed styles
// [RQ4] host puts the low address byte on ad lines before data phase
// [RQ5] rdy_n goes low once a read or write has been carried out; a write gets it low before wr_pulse commits it
// [RQ6] irq_pin_config_reg sets how the interrupt pin behaves
// [RQ7] asserted level of the interrupt pin is selectable high or low
// [RQ8] interrupt pin drives push-pull or open drain
// [RQ9] interrupt pin may serve as a software general-purpose output
// [RQ10] nonmultiplexed styles decode the full nine dedicated address lines
// [RQ11] multiplexed address is captured under the address latch strobe
// [RQ12] no access is taken unless chip select is low
// [RQ13] motorola strobe fall drives read data, its rise takes write data
// [RQ14] shared lines driven only in a selected read, else released
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/10ps
module pbp_top #(
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cs_n,
   input wire logic wr_rw_n,
   input wire logic data_strobe_n,
   input wire logic ale,
   input wire logic addr_hi,
   input wire logic [7:0] addr_lo,
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe,
   output logic rdy_n,
   output logic irq_output_pin,
   output logic irq_output_pin_oe,
   output logic irq
);
   localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [1:0] ctrl, next_ctrl;
   logic [3:0] irq_pin_config_reg, next_cfg;
   logic [2:0] status, next_status;
   logic [2:0] mask, next_mask;
   logic [8:0] last_addr, next_last_addr;
   logic [31:0] next_prdata;
   logic ack, next_ack;
   logic err, next_err;
   logic [7:0] mem [DEPTH];
   logic [7:0] next_mem [DEPTH];

   logic [8:0] host_addr;
   logic host_wr, host_rd;
   logic [7:0] host_wdata;
   logic [7:0] rd_word;
   logic host_hit;
   logic [IDX_W-1:0] host_idx;
   logic [IDX_W-1:0] apb_idx;
   logic data_hit;
   logic apb_wr;
   logic apb_mem_we;
   logic [2:0] events;
   logic [2:0] w1c;

   pbp_host_fsm u_fsm (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .mode_mux(ctrl[pbp_pkg::PBP_CTRL_MUX_BIT]),
      .mode_moto(ctrl[pbp_pkg::PBP_CTRL_MOTO_BIT]),
      .cs_n(cs_n),
      .wr_rw_n(wr_rw_n),
      .data_strobe_n(data_strobe_n),
      .ale(ale),
      .addr_hi(addr_hi),
      .addr_lo(addr_lo),
      .ad_in(ad_in),
      .rd_word(rd_word),
      .host_addr(host_addr),
      .wr_pulse(host_wr),
      .rd_pulse(host_rd),
      .wr_data(host_wdata),
      .ad_out(ad_out),
      .ad_oe(ad_oe),
      .rdy_n(rdy_n)
   );

   // host side decode of the byte array
   always_comb begin
      host_hit = host_addr < 9'(DEPTH);
      host_idx = host_addr[IDX_W-1:0];
      rd_word = host_hit ? mem[host_idx] : 8'h00;
   end

   // apb decode; the slave answers in the first access cycle
   always_comb begin
      apb_idx = paddr[IDX_W+1:2];
      data_hit = (paddr[11:10] == pbp_pkg::PBP_DATA_SEL)
         && (paddr[9:2] < 8'(DEPTH))
         && (paddr[1:0] == 2'h0);
      apb_wr = psel && penable && pwrite && pready;
      apb_mem_we = apb_wr && data_hit;
   end

   always_comb begin
      next_ack = psel && !penable;
      next_err = 1'b1;
      next_prdata = 32'h0000_0000;
      if (data_hit) begin
         next_err = 1'b0;
         next_prdata = {24'h00_0000, mem[apb_idx]};
      end else begin
         case (paddr)
            pbp_pkg::PBP_OFF_CTRL: begin
               next_err = 1'b0;
               next_prdata = {30'h0000_0000, ctrl};
            end
            pbp_pkg::PBP_OFF_IRQ_CFG: begin
               next_err = 1'b0;
               next_prdata = {28'h000_0000, irq_pin_config_reg};
            end
            pbp_pkg::PBP_OFF_STATUS: begin
               next_err = 1'b0;
               next_prdata = {29'h0000_0000, status};
            end
            pbp_pkg::PBP_OFF_MASK: begin
               next_err = 1'b0;
               next_prdata = {29'h0000_0000, mask};
            end
            pbp_pkg::PBP_OFF_LAST_ADDR: begin
               next_err = 1'b0;
               next_prdata = {23'h00_0000, last_addr};
            end
            default: begin
               next_err = 1'b1;
            end
         endcase
      end
      // read data only loads on setup so it stands through the access
      if (!next_ack) begin
         next_prdata = prdata;
         next_err = err;
      end
   end

   always_comb begin
      pready = penable && ack;
      pslverr = pready && err;
   end

   // control registers written by software
   always_comb begin
      next_ctrl = ctrl;
      next_cfg = irq_pin_config_reg;
      next_mask = mask;
      w1c = 3'h0;
      if (apb_wr && !err) begin
         case (paddr)
            pbp_pkg::PBP_OFF_CTRL: begin
               next_ctrl = pwdata[1:0];
            end
            pbp_pkg::PBP_OFF_IRQ_CFG: begin
               next_cfg = pwdata[3:0]; // [RQ6]
            end
            pbp_pkg::PBP_OFF_STATUS: begin
               w1c = pwdata[2:0];
            end
            pbp_pkg::PBP_OFF_MASK: begin
               next_mask = pwdata[2:0];
            end
            default: begin
               w1c = 3'h0;
            end
         endcase
      end
   end

   // sticky events; a new event beats a clear in the same cycle
   always_comb begin
      events = 3'h0;
      events[pbp_pkg::PBP_ST_WR_BIT] = host_wr && host_hit;
      events[pbp_pkg::PBP_ST_RD_BIT] = host_rd && host_hit;
      events[pbp_pkg::PBP_ST_BAD_BIT] = (host_wr || host_rd) && !host_hit;
      next_status = (status & ~w1c) | events;
      next_last_addr = last_addr;
      if (host_wr || host_rd) begin
         next_last_addr = host_addr;
      end
      irq = |(status & mask);
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ctrl <= pbp_pkg::PBP_CTRL_RST;
         irq_pin_config_reg <= pbp_pkg::PBP_CFG_RST;
         status <= pbp_pkg::PBP_STATUS_RST;
         mask <= pbp_pkg::PBP_MASK_RST;
         last_addr <= pbp_pkg::PBP_LAST_ADDR_RST;
         prdata <= 32'h0000_0000;
         ack <= 1'b0;
         err <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         irq_pin_config_reg <= next_cfg;
         status <= next_status;
         mask <= next_mask;
         last_addr <= next_last_addr;
         prdata <= next_prdata;
         ack <= next_ack;
         err <= next_err;
      end
   end

   // byte array; a host write wins over an apb write to the same entry
   for (genvar gi = 0; gi < DEPTH; gi++) begin : g_mem
      always_comb begin
         next_mem[gi] = mem[gi];
         if (host_wr && host_hit && (host_idx == IDX_W'(gi))) begin
            next_mem[gi] = host_wdata; // [RQ1]
         end else if (apb_mem_we && (apb_idx == IDX_W'(gi))) begin
            next_mem[gi] = pwdata[7:0];
         end
      end
      always_ff @(posedge clk_sys or negedge resetn) begin
         if (!resetn) begin
            mem[gi] <= 8'h00;
         end else begin
            mem[gi] <= next_mem[gi];
         end
      end
   end

   pbp_irq_pin u_irq_pin (
      .irq(irq),
      .cfg(irq_pin_config_reg), // [RQ6]
      .pin_o(irq_output_pin),
      .pin_oe(irq_output_pin_oe)
   );

   host_store_a: assert property (@(posedge clk_sys) // [RQ1]
      disable iff (!resetn)
      host_wr && host_hit |=> mem[$past(host_idx)] == $past(host_wdata))
      else $error("host write not stored");
   bad_addr_a: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      (host_wr || host_rd) && !host_hit |=> status[pbp_pkg::PBP_ST_BAD_BIT])
      else $error("unmapped host access not flagged");
   set_wins_a: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      host_wr && host_hit && w1c[pbp_pkg::PBP_ST_WR_BIT]
      |=> status[pbp_pkg::PBP_ST_WR_BIT])
      else $error("event lost to a clear");
   clear_bit_a: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      w1c[pbp_pkg::PBP_ST_RD_BIT] && !events[pbp_pkg::PBP_ST_RD_BIT]
      |=> !status[pbp_pkg::PBP_ST_RD_BIT])
      else $error("status bit not cleared by a one");
   irq_level_a: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      status[pbp_pkg::PBP_ST_WR_BIT] && mask[pbp_pkg::PBP_ST_WR_BIT] |-> irq)
      else $error("unmasked event gives no request");
   irq_quiet_a: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      mask == 3'h0 |-> !irq)
      else $error("request with every event masked");
   last_hold_a: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      !host_wr && !host_rd |=> $stable(last_addr))
      else $error("last address moved without a host access");
   err_zero_a: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      pslverr && !pwrite |-> prdata == 32'h0000_0000)
      else $error("refused read returned data");
   cfg_write_a: assert property (@(posedge clk_sys) // [RQ6]
      disable iff (!resetn)
      apb_wr && !err && paddr == pbp_pkg::PBP_OFF_IRQ_CFG
      |=> irq_pin_config_reg == $past(pwdata[3:0]))
      else $error("pin config not written");
   od_sink_a: assert property (@(posedge clk_sys) // [RQ8]
      disable iff (!resetn)
      irq_pin_config_reg[pbp_pkg::PBP_CFG_OD_BIT] |-> !irq_output_pin)
      else $error("open drain pin driven high");
   od_release_a: assert property (@(posedge clk_sys) // [RQ8]
      disable iff (!resetn)
      irq_pin_config_reg == 4'h2 |-> irq_output_pin_oe == irq)
      else $error("open drain pin not released when idle");
   pol_level_a: assert property (@(posedge clk_sys) // [RQ7]
      disable iff (!resetn)
      !irq_pin_config_reg[pbp_pkg::PBP_CFG_GPO_BIT]
      && !irq_pin_config_reg[pbp_pkg::PBP_CFG_OD_BIT]
      |-> irq_output_pin
      == (irq == irq_pin_config_reg[pbp_pkg::PBP_CFG_POL_BIT]))
      else $error("push-pull request level wrong");
   gpo_value_a: assert property (@(posedge clk_sys) // [RQ9]
      disable iff (!resetn)
      irq_pin_config_reg == 4'h4 |-> !irq_output_pin && irq_output_pin_oe)
      else $error("general purpose output wrong");
   gpo_high_a: assert property (@(posedge clk_sys) // [RQ9]
      disable iff (!resetn)
      irq_pin_config_reg == 4'hC |-> irq_output_pin && irq_output_pin_oe)
      else $error("general purpose output not high");
   apb_answer_a: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      psel && !penable ##1 psel && penable |-> pready)
      else $error("apb access not answered at once");
endmodule

/* design/pbp_pkg.sv */
// shared constants and types of the parallel host bus port
package pbp_pkg;
   localparam int PBP_ADDR_W = 9;
   localparam int PBP_DATA_W = 8;
   localparam int PBP_PADDR_W = 12;
   // apb byte offsets
   localparam logic [11:0] PBP_OFF_CTRL = 12'h000;
   localparam logic [11:0] PBP_OFF_IRQ_CFG = 12'h004;
   localparam logic [11:0] PBP_OFF_STATUS = 12'h008;
   localparam logic [11:0] PBP_OFF_MASK = 12'h00C;
   localparam logic [11:0] PBP_OFF_LAST_ADDR = 12'h010;
   // host-visible byte array, one word per entry from here
   localparam logic [1:0] PBP_DATA_SEL = 2'h1;
   // bus style bits of the control register
   localparam int PBP_CTRL_MUX_BIT = 0;
   localparam int PBP_CTRL_MOTO_BIT = 1;
   localparam logic [1:0] PBP_CTRL_RST = 2'h0;
   // irq_pin_config_reg fields
   localparam int PBP_CFG_POL_BIT = 0;
   localparam int PBP_CFG_OD_BIT = 1;
   localparam int PBP_CFG_GPO_BIT = 2;
   localparam int PBP_CFG_GPV_BIT = 3;
   localparam logic [3:0] PBP_CFG_RST = 4'h0;
   // status and mask layout
   localparam int PBP_ST_WR_BIT = 0;
   localparam int PBP_ST_RD_BIT = 1;
   localparam int PBP_ST_BAD_BIT = 2;
   localparam logic [2:0] PBP_STATUS_RST = 3'h0;
   localparam logic [2:0] PBP_MASK_RST = 3'h0;
   localparam logic [8:0] PBP_LAST_ADDR_RST = 9'h000;

   typedef enum logic [1:0] {
      PBP_IDLE = 2'b00,
      PBP_READ = 2'b01,
      PBP_WRITE = 2'b10
   } pbp_state_t;
endpackage

/* design/pbp_host_fsm.sv */
// pin-level sequencer of the parallel host port
`timescale 1ns/10ps
module pbp_host_fsm (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic mode_mux,
   input wire logic mode_moto,
   input wire logic cs_n,
   input wire logic wr_rw_n,
   input wire logic data_strobe_n,
   input wire logic ale,
   input wire logic addr_hi,
   input wire logic [7:0] addr_lo,
   input wire logic [7:0] ad_in,
   input wire logic [7:0] rd_word,
   output logic [8:0] host_addr,
   output logic wr_pulse,
   output logic rd_pulse,
   output logic [7:0] wr_data,
   output logic [7:0] ad_out,
   output logic ad_oe,
   output logic rdy_n
);
   pbp_pkg::pbp_state_t state, next_state;
   logic [8:0] next_addr;
   logic [7:0] next_wdata, next_rdata;
   logic strobe, rd_dir;

   // data_strobe_n doubles as the read enable in intel styles
   always_comb begin
      strobe = !cs_n && (mode_moto ? !data_strobe_n
                                   : (!data_strobe_n || !wr_rw_n)); // [RQ12]
      rd_dir = mode_moto ? wr_rw_n : !data_strobe_n;
   end

   always_comb begin
      next_addr = host_addr;
      next_state = state;
      next_wdata = wr_data;
      next_rdata = ad_out;
      if (ale) begin
         // low dedicated lines are not looked at in multiplexed styles
         if (mode_mux) begin
            next_addr = {addr_hi, ad_in}; // [RQ2] [RQ11] [RQ3]
         end else begin
            next_addr = {addr_hi, addr_lo}; // [RQ10]
         end
      end
      // keep sampling until the strobe ends: the trailing edge commits
      if (strobe && !rd_dir) begin
         next_wdata = ad_in; // [RQ1] [RQ13]
      end
      case (state)
         pbp_pkg::PBP_IDLE: begin
            if (strobe) begin
               next_state = rd_dir ? pbp_pkg::PBP_READ : pbp_pkg::PBP_WRITE;
               if (rd_dir) begin
                  next_rdata = rd_word; // [RQ1]
               end
            end
         end
         pbp_pkg::PBP_READ: begin
            if (!strobe) begin
               next_state = pbp_pkg::PBP_IDLE;
            end
         end
         pbp_pkg::PBP_WRITE: begin
            if (!strobe) begin
               next_state = pbp_pkg::PBP_IDLE;
            end
         end
         default: begin
            next_state = pbp_pkg::PBP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= pbp_pkg::PBP_IDLE;
         host_addr <= pbp_pkg::PBP_LAST_ADDR_RST;
         wr_data <= 8'h00;
         ad_out <= 8'h00;
      end else begin
         state <= next_state;
         host_addr <= next_addr;
         wr_data <= next_wdata;
         ad_out <= next_rdata;
      end
   end

   always_comb begin
      rd_pulse = (state == pbp_pkg::PBP_IDLE) && strobe && rd_dir;
      wr_pulse = (state == pbp_pkg::PBP_WRITE) && !strobe; // [RQ13]
      // drive the shared lines only inside a selected read
      ad_oe = (state == pbp_pkg::PBP_READ) && strobe && rd_dir; // [RQ14]
      rdy_n = !((state != pbp_pkg::PBP_IDLE) && strobe); // [RQ5]
   end

   sequence wr_held_s;
      (state == pbp_pkg::PBP_WRITE) && strobe;
   endsequence

   sequence wr_end_s;
      wr_held_s ##1 !strobe;
   endsequence

   ready_after_a: assert property (@(posedge clk_sys) // [RQ5]
      disable iff (!resetn)
      (state == pbp_pkg::PBP_IDLE) && strobe ##1 strobe |-> !rdy_n)
      else $error("ready not asserted after strobe start");
   drive_read_a: assert property (@(posedge clk_sys) // [RQ14]
      disable iff (!resetn)
      ad_oe |-> !cs_n && rd_dir && $past(strobe))
      else $error("shared lines driven outside a read");
   no_select_a: assert property (@(posedge clk_sys) // [RQ12]
      disable iff (!resetn)
      cs_n && (state == pbp_pkg::PBP_IDLE) |=> !wr_pulse && rdy_n)
      else $error("access taken without chip select");
   mux_addr_a: assert property (@(posedge clk_sys) // [RQ11]
      disable iff (!resetn)
      mode_mux && ale |=> host_addr == {$past(addr_hi), $past(ad_in)})
      else $error("multiplexed address not latched");
   nonmux_addr_a: assert property (@(posedge clk_sys) // [RQ10]
      disable iff (!resetn)
      !mode_mux && ale |=> host_addr == {$past(addr_hi), $past(addr_lo)})
      else $error("nonmultiplexed address not latched");
   addr_hold_a: assert property (@(posedge clk_sys) // [RQ3]
      disable iff (!resetn)
      !ale |=> $stable(host_addr))
      else $error("address moved with latch closed");
   write_commit_a: assert property (@(posedge clk_sys) // [RQ13]
      disable iff (!resetn)
      wr_end_s |-> wr_pulse && wr_data == $past(ad_in))
      else $error("write data not taken at strobe end");
   read_data_a: assert property (@(posedge clk_sys) // [RQ1]
      disable iff (!resetn)
      rd_pulse |=> ad_out == $past(rd_word))
      else $error("read data not loaded");
endmodule

/* design/pbp_irq_pin.sv */
// output stage of the interrupt request pin
`timescale 1ns/10ps
module pbp_irq_pin (
   input wire logic irq,
   input wire logic [3:0] cfg,
   output logic pin_o,
   output logic pin_oe
);
   logic level;

   always_comb begin
      if (cfg[pbp_pkg::PBP_CFG_GPO_BIT]) begin
         level = cfg[pbp_pkg::PBP_CFG_GPV_BIT]; // [RQ9]
      end else if (cfg[pbp_pkg::PBP_CFG_POL_BIT]) begin
         level = irq; // [RQ7]
      end else begin
         level = !irq; // [RQ7]
      end
      // open drain only ever sinks; the board pull-up gives the high
      if (cfg[pbp_pkg::PBP_CFG_OD_BIT]) begin
         pin_o = 1'b0; // [RQ8]
         pin_oe = !level; // [RQ8]
      end else begin
         pin_o = level;
         pin_oe = 1'b1;
      end
   end
endmodule

/* dv/pbp_host_model.sv */
// behavioural microprocessor on the far side of the parallel port
`timescale 1ns/10ps
module pbp_host_model (
   input wire logic clk_sys,
   input wire logic rdy_n,
   input wire logic [7:0] ad_out,
   input wire logic ad_oe,
   output logic cs_n,
   output logic wr_rw_n,
   output logic data_strobe_n,
   output logic ale,
   output logic addr_hi,
   output logic [7:0] addr_lo,
   output logic [7:0] ad_in
);
   logic h_oe;
   logic [7:0] h_val;
   // released wire shows the inverse of the last value, not a stale copy
   assign ad_in = ad_oe ? ad_out : (h_oe ? h_val : ~h_val);
   initial begin
      cs_n = 1'b1;
      wr_rw_n = 1'b1;
      data_strobe_n = 1'b1;
      ale = 1'b0;
      addr_hi = 1'b0;
      addr_lo = 8'h00;
      h_oe = 1'b0;
      h_val = 8'h00;
   end
   task automatic access(input bit sel, input bit mux, input bit moto,
         input bit wr, input logic [8:0] a, input logic [7:0] d,
         output logic [7:0] q, output bit ok, output logic oe);
      int n;
      @(posedge clk_sys);
      ale <= 1'b1;
      addr_hi <= a[8];
      addr_lo <= mux ? ~a[7:0] : a[7:0];
      h_val <= a[7:0];
      h_oe <= mux;
      @(posedge clk_sys);
      ale <= 1'b0;
      // address pins move on: the latch has to hold
      addr_lo <= ~a[7:0];
      addr_hi <= ~a[8];
      cs_n <= !sel;
      wr_rw_n <= !wr;
      data_strobe_n <= wr & !moto;
      h_val <= d;
      h_oe <= wr;
      ok = 1'b0;
      q = 8'h00;
      oe = 1'b0;
      for (n = 0; n < 8 && !ok; n++) begin
         @(posedge clk_sys);
         if (rdy_n === 1'b0) begin
            ok = 1'b1;
            q = ad_in;
            oe = ad_oe;
         end
      end
      cs_n <= 1'b1;
      wr_rw_n <= 1'b1;
      data_strobe_n <= 1'b1;
      h_oe <= 1'b0;
      @(posedge clk_sys);
   endtask
endmodule

/* dv/test_pbp_top.sv */
// self-checking bench of the parallel host bus port
`timescale 1ns/10ps
`define CHK(g, e, m) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) begin \
         bad_count++; \
         $display("[FAIL] %0t %s", $time, m); \
      end \
   end
module test_pbp_top;
   logic clk_sys, resetn, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, cs_n, wr_rw_n, data_strobe_n, ale, addr_hi;
   logic [7:0] addr_lo, ad_in, ad_out, hq;
   logic ad_oe, rdy_n, irq_output_pin, irq_output_pin_oe, irq, hoe;
   bit hok;
   int bad_count = 0;
   int cmp_count = 0;
   logic [3:0] cfgs [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hC};

   pbp_top #(.DEPTH(16)) u_pbp_top (.clk_sys(clk_sys), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cs_n(cs_n), .wr_rw_n(wr_rw_n),
      .data_strobe_n(data_strobe_n), .ale(ale), .addr_hi(addr_hi),
      .addr_lo(addr_lo), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
      .rdy_n(rdy_n), .irq_output_pin(irq_output_pin),
      .irq_output_pin_oe(irq_output_pin_oe), .irq(irq));
   pbp_host_model u_pbp_host_model (.clk_sys(clk_sys), .rdy_n(rdy_n),
      .ad_out(ad_out), .ad_oe(ad_oe), .cs_n(cs_n), .wr_rw_n(wr_rw_n),
      .data_strobe_n(data_strobe_n), .ale(ale), .addr_hi(addr_hi),
      .addr_lo(addr_lo), .ad_in(ad_in));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         $display("[FAIL] %0t apb wait ran out", $time);
         tally_and_finish();
      end else begin
         @(negedge clk_sys);
      end
   endtask

   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
         input string m);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      `CHK(q, x, m)
   endtask

   task automatic host(input bit sel, input bit mux, input bit moto,
         input bit wr, input logic [8:0] a, input logic [7:0] d);
      u_pbp_host_model.access(sel, mux, moto, wr, a, d, hq, hok, hoe);
      if (sel && !hok) begin
         bad_count++;
         $display("[FAIL] %0t host wait ran out", $time);
         tally_and_finish();
      end else begin
         @(negedge clk_sys);
      end
   endtask

   function automatic logic [11:0] arr(input logic [8:0] a);
      return 12'h400 + 12'({a, 2'b00});
   endfunction

   // returns {level, enable}; open drain only tried active low
   function automatic logic [1:0] pin_exp(input logic [3:0] c,
         input logic i);
      if (c[2]) return {c[3], 1'b1};
      if (c[1]) return {1'b0, i};
      return {c[0] ~^ i, 1'b1};
   endfunction

   task automatic t_reset();
      `CHK({rdy_n, ad_oe}, 2'b10, "idle pins")
      `CHK({irq_output_pin, irq_output_pin_oe}, 2'b11, "irq pin")
      rd_chk(pbp_pkg::PBP_OFF_CTRL, 32'h0, "ctrl reset");
      rd_chk(pbp_pkg::PBP_OFF_IRQ_CFG, 32'h0, "cfg reset");
      rd_chk(pbp_pkg::PBP_OFF_STATUS, 32'h0, "status reset");
      rd_chk(pbp_pkg::PBP_OFF_MASK, 32'h0, "mask reset");
      rd_chk(pbp_pkg::PBP_OFF_LAST_ADDR, 32'h0, "last reset");
      $display("done reset");
   endtask

   task automatic t_styles();
      logic [8:0] a;
      logic [7:0] d;
      for (int s = 0; s < 4; s++) begin
         a = 9'(s + 1);
         d = 8'(90 + 17 * s);
         wr32(pbp_pkg::PBP_OFF_CTRL, 32'(s));
         host(1'b1, s[0], s[1], 1'b1, a, d);
         `CHK({hok, hoe}, 2'b10, "write ack")
         `CHK({rdy_n, ad_oe}, 2'b10, "release")
         host(1'b1, s[0], s[1], 1'b0, a, 8'h00);
         `CHK(hq, d, "read back")
         `CHK({hok, hoe}, 2'b11, "read drive")
         rd_chk(arr(a), 32'(d), "array");
         rd_chk(pbp_pkg::PBP_OFF_LAST_ADDR, 32'(a), "last");
      end
      $display("done styles");
   endtask

   task automatic t_high();
      logic [31:0] q;
      logic e;
      wr32(pbp_pkg::PBP_OFF_STATUS, 32'h7);
      wr32(pbp_pkg::PBP_OFF_CTRL, 32'h1);
      host(1'b1, 1'b1, 1'b0, 1'b0, 9'h102, 8'h00);
      `CHK(hq, 8'h00, "high read")
      rd_chk(pbp_pkg::PBP_OFF_LAST_ADDR, 32'h102, "high");
      apb(1'b0, pbp_pkg::PBP_OFF_STATUS, 32'h0, q, e);
      `CHK(q[2], 1'b1, "range flag")
      wr32(pbp_pkg::PBP_OFF_STATUS, 32'h7);
      rd_chk(pbp_pkg::PBP_OFF_STATUS, 32'h0, "w1c");
      $display("done high");
   endtask

   task automatic t_nosel();
      host(1'b0, 1'b1, 1'b0, 1'b1, 9'h001, 8'h33);
      `CHK({hok, ad_oe}, 2'b00, "unselected")
      rd_chk(arr(9'h001), 32'h5A, "kept");
      rd_chk(pbp_pkg::PBP_OFF_STATUS, 32'h0, "no event");
      $display("done nosel");
   endtask

   task automatic pin_loop(input logic i);
      logic [1:0] e;
      foreach (cfgs[k]) begin
         wr32(pbp_pkg::PBP_OFF_IRQ_CFG, 32'(cfgs[k]));
         e = pin_exp(cfgs[k], i);
         `CHK(irq_output_pin_oe, e[0], "pin oe")
         if (e[0]) `CHK(irq_output_pin, e[1], "pin lvl")
      end
   endtask

   task automatic t_irq();
      wr32(pbp_pkg::PBP_OFF_MASK, 32'h1);
      host(1'b1, 1'b1, 1'b0, 1'b1, 9'h005, 8'h77);
      `CHK(irq, 1'b1, "irq raised")
      pin_loop(1'b1);
      wr32(pbp_pkg::PBP_OFF_MASK, 32'h0);
      `CHK(irq, 1'b0, "irq masked")
      pin_loop(1'b0);
      wr32(pbp_pkg::PBP_OFF_MASK, 32'h1);
      `CHK(irq, 1'b1, "irq unmasked")
      wr32(pbp_pkg::PBP_OFF_STATUS, 32'h1);
      `CHK(irq, 1'b0, "irq cleared")
      $display("done irq");
   endtask

   task automatic t_err();
      logic [31:0] q;
      logic e;
      apb(1'b0, 12'h014, 32'h0, q, e);
      `CHK({e, q}, {1'b1, 32'h0}, "unmapped read")
      apb(1'b1, 12'h018, 32'hFF, q, e);
      `CHK(e, 1'b1, "unmapped write")
      wr32(pbp_pkg::PBP_OFF_LAST_ADDR, 32'h1FF);
      rd_chk(pbp_pkg::PBP_OFF_LAST_ADDR, 32'h005, "read only");
      $display("done err");
   endtask

   // the clear lands on the edge that commits the host write
   task automatic t_race();
      fork
         host(1'b1, 1'b1, 1'b0, 1'b1, 9'h006, 8'h5C);
         begin
            repeat (2) @(posedge clk_sys);
            wr32(pbp_pkg::PBP_OFF_STATUS, 32'h1);
         end
      join
      rd_chk(pbp_pkg::PBP_OFF_STATUS, 32'h1, "set wins");
      rd_chk(arr(9'h006), 32'h5C, "race store");
      $display("done race");
   endtask

   initial begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      @(negedge clk_sys);
      t_reset();
      t_styles();
      t_high();
      t_nosel();
      t_irq();
      t_err();
      t_race();
      tally_and_finish();
   end
endmodule
